// ===== src/port_routing_pkg.sv
// constants, register map and field layout for the port output routing block
package port_routing_pkg;
   localparam logic [7:0] addr_output_value     = 8'h00;
   localparam logic [7:0] addr_level_readback   = 8'h04;
   localparam logic [7:0] addr_bypass_select    = 8'h08;
   localparam logic [7:0] addr_bidir_enable     = 8'h0c;
   localparam logic [7:0] addr_drive_mode0      = 8'h10;
   localparam logic [7:0] addr_drive_mode1      = 8'h14;
   localparam logic [7:0] addr_drive_mode2      = 8'h18;
   localparam logic [7:0] addr_out_choice_lo    = 8'h1c;
   localparam logic [7:0] addr_out_choice_hi    = 8'h20;
   localparam logic [7:0] addr_oe_choice_lo     = 8'h24;
   localparam logic [7:0] addr_oe_choice_hi     = 8'h28;
   localparam logic [7:0] addr_analog_global    = 8'h2c;
   localparam logic [7:0] addr_analog_mux       = 8'h30;
   localparam logic [7:0] addr_input_disable    = 8'h34;
   localparam logic [7:0] addr_lcd_enable       = 8'h38;
   localparam logic [7:0] addr_lcd_com_seg      = 8'h3c;
   localparam logic [7:0] addr_pair_config      = 8'h40;
   localparam logic [7:0] addr_pair_threshold   = 8'h44;
   localparam logic [7:0] addr_config_alias     = 8'h48;
   localparam logic [7:0] addr_system_options   = 8'h4c;
   localparam logic [7:0] addr_memory_mode      = 8'h50;
   // alias field: [0] bypass, [1] bidir, [4:2] drive mode, [5] input disable
   localparam int         alias_byp_bit         = 0;
   localparam int         alias_bie_bit         = 1;
   localparam int         alias_dm_lsb          = 2;
   localparam int         alias_inp_bit         = 5;
   // system options: [1:0] serial bus pins, [2] reset on alternate, [3] debug on gpio
   localparam int         opt_reset_alt_bit     = 2;
   localparam int         opt_debug_gpio_bit    = 3;
   localparam logic [7:0] reset_zero            = 8'h00;
   localparam logic [1:0] axi_okay              = 2'b00;
   localparam logic [1:0] axi_slverr            = 2'b10;
   localparam logic [2:0] dm_hiz_analog         = 3'h0;
   localparam logic [2:0] dm_hiz_digital        = 3'h1;
   localparam logic [2:0] dm_pull_up            = 3'h2;
   localparam logic [2:0] dm_pull_down          = 3'h3;
   localparam logic [2:0] dm_drain_low          = 3'h4;
   localparam logic [2:0] dm_drain_high         = 3'h5;
   localparam logic [2:0] dm_strong             = 3'h6;
   localparam logic [2:0] dm_pull_both          = 3'h7;
   // fast bus register selector
   typedef enum logic [1:0] {
      fast_value  = 2'h0,
      fast_select = 2'h1,
      fast_read   = 2'h2
   } fast_reg_t;
endpackage

// ===== src/port_output_routing.sv
// one eight-pin port: output routing, dynamic enable, config registers, axi slave
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module port_output_routing #(
   parameter int                 PORT_NUMBER = 0,   // selects fast bus presence
   parameter int                 PINS        = 8    // pins per port
) (
   input  wire logic             sys_clk_in,
   input  wire logic             sys_rst_in,
   // axi4-lite slave (peripheral hub)
   input  wire logic [7:0]       s_awaddr_in,
   input  wire logic             s_awvalid_in,
   output logic                  s_awready_out,
   input  wire logic [31:0]      s_wdata_in,
   input  wire logic [3:0]       s_wstrb_in,
   input  wire logic             s_wvalid_in,
   output logic                  s_wready_out,
   output logic [1:0]            s_bresp_out,
   output logic                  s_bvalid_out,
   input  wire logic             s_bready_in,
   input  wire logic [7:0]       s_araddr_in,
   input  wire logic             s_arvalid_in,
   output logic                  s_arready_out,
   output logic [31:0]           s_rdata_out,
   output logic [1:0]            s_rresp_out,
   output logic                  s_rvalid_out,
   input  wire logic             s_rready_in,
   // processor special-function bus
   input  wire logic             fast_wr_in,
   input  wire logic             fast_rd_in,
   input  wire port_routing_pkg::fast_reg_t fast_reg_in,
   input  wire logic [7:0]       fast_wdata_in,
   output logic [7:0]            fast_rdata_out,
   // fabric connection
   input  wire logic [7:0]       fabric_out_in,
   input  wire logic [3:0]       fabric_ctl_in,
   output logic [7:0]            fabric_pin_out,
   // pads
   input  wire logic [7:0]       pad_in,
   output logic [7:0]            pad_out,
   output logic [7:0]            pad_oe_out,
   output logic [7:0]            pad_ibuf_en_out,
   output logic [23:0]           pad_drive_mode_out,
   output logic [7:0]            analog_global_out,
   output logic [7:0]            analog_mux_out,
   output logic [7:0]            lcd_enable_out,
   output logic [7:0]            lcd_com_seg_out,
   output logic [7:0]            pair_config_out,
   output logic [7:0]            pair_threshold_out,
   // external memory mode
   input  wire logic [7:0]       mem_wdata_in,
   input  wire logic             mem_drive_in,
   output logic [7:0]            mem_rdata_out,
   // system pin options
   input  wire logic             reset_pin_low_in,
   output logic                  external_reset_low_out,
   output logic [1:0]            serial_bus_pins_out,
   output logic                  debug_on_gpio_out
);
   import port_routing_pkg::*;

   // fast bus exists only on ports 0-6, 12 and 15
   localparam bit HAS_FAST = (PORT_NUMBER <= 6) || (PORT_NUMBER == 12) ||
                             (PORT_NUMBER == 15);

   // elaboration guards: the pin loops are written for eight pins only
   if (PINS != 8) $error("port width must be eight");
   if (PORT_NUMBER < 0 || PORT_NUMBER > 15) $error("port number out of range");

   // configuration state
   logic [7:0]  out_value;      // port data register
   logic [7:0]  bypass;         // fabric bypass
   logic [7:0]  bidir;          // dynamic enable gate
   logic [7:0]  dm0, dm1, dm2;  // drive mode planes
   logic [7:0]  ochoice_lo, ochoice_hi, oechoice_lo, oechoice_hi;
   logic [7:0]  ag, amux, inp_dis, lcd_en, lcd_cs, pcfg, pthr;
   logic [7:0]  fast_value_r;   // fast bus value
   logic [7:0]  fast_sel_r;     // fast bus select
   logic [7:0]  sys_opts;       // pin option register
   logic        mem_mode;       // external memory mode

   // axi write channel capture
   logic        aw_held, w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;          // both halves present, response free
   logic        wr_hit;         // address mapped

   assign s_awready_out = !aw_held;
   assign s_wready_out  = !w_held;
   assign wr_go = aw_held && w_held && !s_bvalid_out;

   // address and data held independently, either order
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_awvalid_in && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr_in;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_wvalid_in && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_wdata_in;
            w_strb <= s_wstrb_in;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // decode of writable addresses
   always_comb begin
      unique case (aw_addr)
         addr_output_value, addr_bypass_select, addr_bidir_enable,
         addr_drive_mode0, addr_drive_mode1, addr_drive_mode2,
         addr_out_choice_lo, addr_out_choice_hi, addr_oe_choice_lo,
         addr_oe_choice_hi, addr_analog_global, addr_analog_mux,
         addr_input_disable, addr_lcd_enable, addr_lcd_com_seg,
         addr_pair_config, addr_pair_threshold, addr_config_alias,
         addr_system_options, addr_memory_mode: wr_hit = 1'b1;
         default: wr_hit = 1'b0;  // readback is read only
      endcase
   end

   // write response: slverr for unmapped address
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_bvalid_out <= 1'b0;
         s_bresp_out  <= axi_okay;
      end else if (wr_go) begin
         s_bvalid_out <= 1'b1;
         s_bresp_out  <= wr_hit ? axi_okay : axi_slverr;
      end else if (s_bready_in) begin
         s_bvalid_out <= 1'b0;
      end
   end

   logic        hub_we;         // hub write to a byte-lane-0 register
   assign hub_we = wr_go && wr_hit && w_strb[0];

   // port data register: hub and fast bus share it
   // a fast write in the same cycle lands after the hub one, so it wins
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         out_value <= reset_zero;
      end else if (HAS_FAST && fast_wr_in && fast_reg_in == fast_value) begin
         out_value <= fast_wdata_in;
      end else if (hub_we && aw_addr == addr_output_value) begin
         out_value <= w_data[7:0];
      end
   end

   // fast bus value and select registers
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in || !HAS_FAST) begin
         fast_value_r <= reset_zero;
         fast_sel_r   <= reset_zero;
      end else if (fast_wr_in) begin
         if (fast_reg_in == fast_value)  fast_value_r <= fast_wdata_in;
         if (fast_reg_in == fast_select) fast_sel_r   <= fast_wdata_in;
      end
   end

   // per-pin configuration; the alias writes a subset to every pin at once
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         {bypass, bidir, dm0, dm1, dm2, inp_dis} <= '0;
         {ochoice_lo, ochoice_hi, oechoice_lo, oechoice_hi} <= '0;
         {ag, amux, lcd_en, lcd_cs, pcfg, pthr} <= '0;
         sys_opts <= reset_zero;
         mem_mode <= 1'b0;
      end else if (hub_we) begin
         unique case (aw_addr)
            addr_bypass_select:  bypass      <= w_data[7:0];
            addr_bidir_enable:   bidir       <= w_data[7:0];
            addr_drive_mode0:    dm0         <= w_data[7:0];
            addr_drive_mode1:    dm1         <= w_data[7:0];
            addr_drive_mode2:    dm2         <= w_data[7:0];
            addr_out_choice_lo:  ochoice_lo  <= w_data[7:0];
            addr_out_choice_hi:  ochoice_hi  <= w_data[7:0];
            addr_oe_choice_lo:   oechoice_lo <= w_data[7:0];
            addr_oe_choice_hi:   oechoice_hi <= w_data[7:0];
            addr_analog_global:  ag          <= w_data[7:0];
            addr_analog_mux:     amux        <= w_data[7:0];
            addr_input_disable:  inp_dis     <= w_data[7:0];
            addr_lcd_enable:     lcd_en      <= w_data[7:0];
            addr_lcd_com_seg:    lcd_cs      <= w_data[7:0];
            addr_pair_config:    pcfg        <= w_data[7:0];
            addr_pair_threshold: pthr        <= w_data[7:0];
            addr_system_options: sys_opts    <= w_data[7:0];
            addr_memory_mode:    mem_mode    <= w_data[0];
            addr_config_alias: begin
               bypass  <= {8{w_data[alias_byp_bit]}};
               bidir   <= {8{w_data[alias_bie_bit]}};
               dm0     <= {8{w_data[alias_dm_lsb]}};
               dm1     <= {8{w_data[alias_dm_lsb+1]}};
               dm2     <= {8{w_data[alias_dm_lsb+2]}};
               inp_dis <= {8{w_data[alias_inp_bit]}};
            end
            default: ;  // data register handled above
         endcase
      end
   end

   // per-pin output path
   logic [7:0] next_pad_out, next_oe, next_ibuf;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         logic [1:0] osel;
         logic [1:0] esel;
         logic [2:0] dm;
         logic       dyn_hiz;
         osel = {ochoice_hi[i], ochoice_lo[i]};
         esel = {oechoice_hi[i], oechoice_lo[i]};
         dm   = {dm2[i], dm1[i], dm0[i]};
         // bidir gates the dynamic control; zero keeps output enabled
         dyn_hiz    = bidir[i] && fabric_ctl_in[esel];
         // bypass picks among four fabric outputs; fabric bits i, i+2, i+4, i+6 wrap
         next_pad_out[i] = bypass[i] ? fabric_out_in[(i + 2*osel) % 8]
                                     : out_value[i];
         if (fast_sel_r[i]) next_pad_out[i] = fast_value_r[i];
         if (mem_mode) next_pad_out[i] = mem_wdata_in[i];
         next_oe[i] = !(dm == dm_hiz_analog || dm == dm_hiz_digital) &&
                      !dyn_hiz && !lcd_en[i];
         if (mem_mode) next_oe[i] = mem_drive_in;
         next_ibuf[i] = (dm != dm_hiz_analog || dyn_hiz) && !inp_dis[i];
      end
   end

   // pad outputs registered
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pad_out         <= reset_zero;
         pad_oe_out      <= reset_zero;
         pad_ibuf_en_out <= reset_zero;
      end else begin
         pad_out         <= next_pad_out;
         pad_oe_out      <= next_oe;
         pad_ibuf_en_out <= next_ibuf;
      end
   end

   // input path: gated pin levels registered to fabric and readback, raw pad levels to memory data
   logic [7:0] pin_level;
   assign pin_level = pad_in & pad_ibuf_en_out;
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         fabric_pin_out <= reset_zero;
         mem_rdata_out  <= reset_zero;
         fast_rdata_out <= reset_zero;
      end else begin
         fabric_pin_out <= pin_level;
         mem_rdata_out  <= pad_in;
         if (HAS_FAST && fast_rd_in) begin
            unique case (fast_reg_in)
               fast_value:  fast_rdata_out <= fast_value_r;
               fast_select: fast_rdata_out <= fast_sel_r;
               default:     fast_rdata_out <= pin_level;
            endcase
         end
      end
   end

   // static configuration outputs
   always_comb begin
      pad_drive_mode_out = {dm2, dm1, dm0};
      analog_global_out  = ag;
      analog_mux_out     = amux;
      lcd_enable_out     = lcd_en;
      lcd_com_seg_out    = lcd_cs;
      pair_config_out    = pcfg;
      pair_threshold_out = pthr;
      serial_bus_pins_out = sys_opts[1:0];
      debug_on_gpio_out  = sys_opts[opt_debug_gpio_bit];
      // alternate pin reset only when option set
      external_reset_low_out = reset_pin_low_in &&
         !(sys_opts[opt_reset_alt_bit] && !pad_in[2] && PORT_NUMBER == 1);
   end

   // axi read: one cycle answer
   logic [7:0] rd_byte;
   logic       rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_araddr_in)
         addr_output_value:   rd_byte = out_value;
         addr_level_readback: rd_byte = pin_level;
         addr_bypass_select:  rd_byte = bypass;
         addr_bidir_enable:   rd_byte = bidir;
         addr_drive_mode0:    rd_byte = dm0;
         addr_drive_mode1:    rd_byte = dm1;
         addr_drive_mode2:    rd_byte = dm2;
         addr_out_choice_lo:  rd_byte = ochoice_lo;
         addr_out_choice_hi:  rd_byte = ochoice_hi;
         addr_oe_choice_lo:   rd_byte = oechoice_lo;
         addr_oe_choice_hi:   rd_byte = oechoice_hi;
         addr_analog_global:  rd_byte = ag;
         addr_analog_mux:     rd_byte = amux;
         addr_input_disable:  rd_byte = inp_dis;
         addr_lcd_enable:     rd_byte = lcd_en;
         addr_lcd_com_seg:    rd_byte = lcd_cs;
         addr_pair_config:    rd_byte = pcfg;
         addr_pair_threshold: rd_byte = pthr;
         addr_system_options: rd_byte = sys_opts;
         addr_memory_mode:    rd_byte = {7'h00, mem_mode};
         default: begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;  // alias reads as error too
         end
      endcase
   end

   assign s_arready_out = !s_rvalid_out;
   // read data held until taken
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_rvalid_out <= 1'b0;
         s_rdata_out  <= 32'h0000_0000;
         s_rresp_out  <= axi_okay;
      end else if (s_arvalid_in && !s_rvalid_out) begin
         s_rvalid_out <= 1'b1;
         s_rdata_out  <= {24'h000000, rd_byte};
         s_rresp_out  <= rd_hit ? axi_okay : axi_slverr;
      end else if (s_rready_in) begin
         s_rvalid_out <= 1'b0;
      end
   end

   // checks
   AST_FAST_DRIVES: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && fast_sel_r[0] |=> pad_out[0] == $past(fast_value_r[0]))
      else $error("fast select did not drive pin");
   AST_BYPASS_DATA: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && !fast_sel_r[1] && !bypass[1] |=> pad_out[1] == $past(out_value[1]))
      else $error("data register not driving pin");
   AST_BYPASS_FAB: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && !fast_sel_r[0] && bypass[0] && !ochoice_lo[0] && !ochoice_hi[0]
      |=> pad_out[0] == $past(fabric_out_in[0]))
      else $error("fabric output not routed");
   AST_DYN_HIZ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && bidir[0] && fabric_ctl_in[{oechoice_hi[0], oechoice_lo[0]}]
      |=> !pad_oe_out[0])
      else $error("dynamic control did not tristate");
   AST_LCD_HIZ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && lcd_en[7] |=> !pad_oe_out[7])
      else $error("lcd pin still driven");
   AST_INP_DIS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      inp_dis[0] |=> !pad_ibuf_en_out[0])
      else $error("input buffer not disabled");
   AST_ALWAYS_EN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !mem_mode && !bidir[5] && !lcd_en[5] && dm2[5] && dm1[5] |=> pad_oe_out[5])
      else $error("strong pin not enabled");
   AST_ALIAS: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      hub_we && aw_addr == addr_config_alias |=> bypass == {8{$past(w_data[0])}})
      else $error("alias did not fill port");
   AST_LAST_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      HAS_FAST && fast_wr_in && fast_reg_in == fast_value
      |=> out_value == $past(fast_wdata_in))
      else $error("fast write lost");
   AST_READ_ONE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      s_arvalid_in && s_arready_out |=> s_rvalid_out)
      else $error("read answer late");
   COV_ALIAS: cover property (@(posedge sys_clk_in) hub_we && aw_addr == addr_config_alias);
   COV_FAST: cover property (@(posedge sys_clk_in) fast_wr_in && fast_reg_in == fast_select);
   COV_DYN: cover property (@(posedge sys_clk_in) bidir != 8'h00 && fabric_ctl_in != 4'h0);
   COV_MEM: cover property (@(posedge sys_clk_in) mem_mode && mem_drive_in);
endmodule

// ===== tb/fabric_model.sv
// fabric-side model: routed output levels, control levels and captured pins
`timescale 1ns/1ps
module fabric_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] level_in,  // levels the fabric logic wants out
   input  wire logic [3:0] ctl_in,    // dynamic control levels wanted
   input  wire logic [7:0] pin_in,    // pin levels routed up from the port
   output logic      [7:0] fab_out,   // toward the port, from a flop
   output logic      [3:0] ctl_out,   // toward the port, from a flop
   output logic      [7:0] seen_out   // pins as the fabric sees them
);
   // launched from flops like real routed logic, so glitch-free and one cycle late
   always_ff @(posedge clk_in) begin
      fab_out <= level_in;
      ctl_out <= ctl_in;
      seen_out <= pin_in;
   end
endmodule

// ===== tb/test_port_output_routing.sv
// bench: hub and fast bus traffic against one port, pins checked
`timescale 1ns/1ps
module test_port_output_routing;
   import port_routing_pkg::*;
   logic        sys_clk_in, sys_rst_in, aw_v, w_v, b_r, ar_v, r_r, fwr, frd, mdrv, rpin;
   logic [7:0]  awaddr, araddr, fwd, lvl, pin, mwd;
   logic [31:0] wdata;
   logic [3:0]  ctl;
   fast_reg_t   freg;
   wire logic   aw_r, w_r, b_v, ar_r, rv;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0]  frdata, fpin, pad_o, oe_o, ag_o, mrd, fab;
   wire logic [3:0]  fctl;
   wire logic [23:0] dm_o;
   wire logic [7:0]  ibuf_o, amux_o, lcs_o, pcfg_o, pthr_o;
   wire logic [1:0]  sbp;
   wire logic        dbg, xrst;
   int          error_cnt, checks, cnt;
   // device under test, port 0 has the fast bus
   port_output_routing #(.PORT_NUMBER(0), .PINS(8)) DUT (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .s_awaddr_in(awaddr), .s_awvalid_in(aw_v), .s_awready_out(aw_r),
      .s_wdata_in(wdata), .s_wstrb_in(4'hf), .s_wvalid_in(w_v), .s_wready_out(w_r),
      .s_bresp_out(bresp), .s_bvalid_out(b_v), .s_bready_in(b_r),
      .s_araddr_in(araddr), .s_arvalid_in(ar_v), .s_arready_out(ar_r),
      .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rv), .s_rready_in(r_r),
      .fast_wr_in(fwr), .fast_rd_in(frd), .fast_reg_in(freg), .fast_wdata_in(fwd),
      .fast_rdata_out(frdata), .fabric_out_in(fab), .fabric_ctl_in(fctl),
      .fabric_pin_out(fpin), .pad_in(pin), .pad_out(pad_o), .pad_oe_out(oe_o),
      .pad_ibuf_en_out(ibuf_o), .pad_drive_mode_out(dm_o), .analog_global_out(ag_o),
      .analog_mux_out(amux_o), .lcd_enable_out(), .lcd_com_seg_out(lcs_o),
      .pair_config_out(pcfg_o), .pair_threshold_out(pthr_o), .mem_wdata_in(mwd),
      .mem_drive_in(mdrv), .mem_rdata_out(mrd), .reset_pin_low_in(rpin),
      .external_reset_low_out(xrst), .serial_bus_pins_out(sbp), .debug_on_gpio_out(dbg));
   // far side: fabric logic feeding outputs and controls
   fabric_model fabric (.clk_in(sys_clk_in), .level_in(lvl), .ctl_in(ctl),
      .pin_in(fpin), .fab_out(fab), .ctl_out(fctl), .seen_out());
   // 50 ns clock
   initial begin
      sys_clk_in = 0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   // hang guard, run needs well under a thousand cycles
   always @(posedge sys_clk_in) begin
      cnt++;
      if (cnt == 4000) begin
         error_cnt++;
         final_report;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hub write; each channel released at its own handshake
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd, bd;
      @(posedge sys_clk_in);
      {awaddr, wdata, aw_v, w_v, b_r} <= {a, d, 3'b111};
      do begin
         @(negedge sys_clk_in);
         {ad, wd, bd} = {aw_v & aw_r, w_v & w_r, b_v};
         if (bd) chk(bresp, axi_okay);
         @(posedge sys_clk_in);
         if (ad) aw_v <= 0;
         if (wd) w_v <= 0;
         if (bd) b_r <= 0;
      end while (!bd);
   endtask
   // hub read with expected data and response
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ad, rd_seen;
      @(posedge sys_clk_in);
      {araddr, ar_v, r_r} <= {a, 2'b11};
      do begin
         @(negedge sys_clk_in);
         {ad, rd_seen} = {ar_v & ar_r, rv};
         if (rd_seen) chk({rresp, rdata}, {er, e});
         @(posedge sys_clk_in);
         if (ad) ar_v <= 0;
         if (rd_seen) r_r <= 0;
      end while (!rd_seen);
   endtask
   // fast bus strobes last one cycle
   task fw(input fast_reg_t r, input logic [7:0] d);
      @(posedge sys_clk_in);
      freg <= r;
      {fwd, fwr} <= {d, 1'b1};
      @(posedge sys_clk_in);
      fwr <= 0;
   endtask
   task fr(input fast_reg_t r, input logic [7:0] e);
      @(posedge sys_clk_in);
      freg <= r;
      frd <= 1'b1;
      @(posedge sys_clk_in);
      frd <= 0;
      @(negedge sys_clk_in);
      chk(frdata, e);
   endtask
   // pin level and enable after the fabric flop and the pad flop
   task pn(input logic [7:0] eo, input logic [7:0] eoe);
      repeat (3) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk({pad_o, oe_o}, {eo, eoe});
   endtask
   function automatic logic [7:0] rot(input logic [7:0] v, input int s);
      for (int i = 0; i < 8; i++) rot[i] = v[(i + 2 * s) % 8];
   endfunction
   task final_report;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence
   initial begin
      {aw_v, w_v, b_r, ar_v, r_r, fwr, frd, mdrv} = '0;
      {awaddr, araddr, fwd, lvl, pin, mwd, wdata, ctl} = '0;
      freg = fast_value;
      rpin = 1'b1;
      {error_cnt, checks, cnt} = '0;
      sys_rst_in = 1;
      repeat (16) @(posedge sys_clk_in);
      sys_rst_in <= 0;
      rd(addr_output_value, 32'h0, axi_okay);
      chk(xrst, 1'b1);
      rd(8'h60, 32'h0, axi_slverr);
      wr(addr_config_alias, 32'h18);
      rd(addr_drive_mode0, 32'h0, axi_okay);
      rd(addr_drive_mode2, 32'hff, axi_okay);
      chk(dm_o, 24'hffff00);
      wr(addr_output_value, 32'h5a);
      pn(8'h5a, 8'hff);
      fw(fast_select, 8'h0f);
      fw(fast_value, 8'h03);
      // a fast value write also lands in the data register, so the upper nibble clears
      pn(8'h03, 8'hff);
      fr(fast_value, 8'h03);
      fw(fast_select, 8'h00);
      lvl <= 8'hc5;
      wr(addr_bypass_select, 32'hff);
      wr(addr_out_choice_lo, 32'hff);
      pn(rot(8'hc5, 1), 8'hff);
      wr(addr_out_choice_lo, 32'h0);
      pn(8'hc5, 8'hff);
      wr(addr_bidir_enable, 32'h01);
      ctl <= 4'h1;
      pn(8'hc5, 8'hfe);
      wr(addr_oe_choice_lo, 32'h01);
      pn(8'hc5, 8'hff);
      ctl <= 4'h0;
      wr(addr_lcd_enable, 32'h80);
      pn(8'hc5, 8'h7f);
      wr(addr_analog_global, 32'h33);
      chk(ag_o, 8'h33);
      wr(addr_analog_mux, 32'h44);
      wr(addr_lcd_com_seg, 32'h81);
      chk({amux_o, lcs_o}, 16'h4481);
      wr(addr_pair_config, 32'h03);
      wr(addr_pair_threshold, 32'h02);
      chk({pcfg_o, pthr_o}, 16'h0302);
      wr(addr_system_options, 32'h0a);
      rpin <= 1'b0;
      @(negedge sys_clk_in);
      chk({dbg, sbp, xrst}, 4'b1100);
      pin <= 8'hff;
      wr(addr_input_disable, 32'h0f);
      pn(8'hc5, 8'h7f);
      chk(fpin, 8'hf0);
      chk(ibuf_o, 8'hf0);
      {mwd, mdrv, pin} <= {8'h99, 1'b1, 8'h3c};
      wr(addr_memory_mode, 32'h1);
      pn(8'h99, 8'hff);
      chk(mrd, 8'h3c);
      final_report;
   end
endmodule
